// ---- core/ocfl_regs.vh ----
`ifndef OCFL_REGS_VH
`define OCFL_REGS_VH
// command code of the limit register on the management link
`define OCFL_CMD_CODE 8'h46
// linear format layout
`define OCFL_EXP_MSB 15
`define OCFL_EXP_LSB 11
`define OCFL_MAN_MSB 10
`define OCFL_MAN_LSB 0
`define OCFL_EXP_FIXED 5'h1f
`define OCFL_MAN_RESET 11'h03c
`define OCFL_MAN_MIN 11'h006
`define OCFL_MAN_MAX 11'h064
// page selections
`define OCFL_PAGE_CH1 8'h00
`define OCFL_PAGE_CH2 8'h01
`define OCFL_PAGE_BOTH 8'h0b
`endif

// ---- core/ocfl_chan.v ----
`timescale 1ns/1ps
`include "ocfl_regs.vh"
// one channel's mantissa store and over-current compare
module ocfl_chan (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire wr_in,
   input wire [10:0] man_in,
   input wire [15:0] iout_in,
   output wire [10:0] man_out,
   output wire oc_out
);
   reg [10:0] man_ff;
   wire [10:0] nxt_man;
   // only the mantissa bits take writes; range checks live in the parent
   assign nxt_man = wr_in ? man_in : man_ff;
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         man_ff <= `OCFL_MAN_RESET;
      end else if (ce_in) begin
         man_ff <= nxt_man;
      end
   end
   assign man_out = man_ff;
   // signed compare: current word shares the limit's 0.5 a lsb
   assign oc_out = ($signed(iout_in) >= $signed({{5{man_ff[10]}}, man_ff}));
endmodule // ocfl_chan

// ---- core/ocfl_top.v ----
`timescale 1ns/1ps
`include "ocfl_regs.vh"
// Behaviour
// - exponent lives in bits 15:11 and reads as -1, giving 0.5 a steps
// - exponent never changes, whatever is written
// - eleven-bit mantissa in bits 10:0, resets to 60 (30 a)
// - writes to read-only bits are dropped, mantissa bits are taken
// - one copy per channel; page 0, page 1, page 11 both
// - limit below warning limit sets cml and ivd bits and alert
// - write to channel two as slave is nacked, flags ivc and alert
module ocfl_top (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire [7:0] page_in,
   input wire [7:0] cmd_in,
   input wire wr_in,
   input wire rd_in,
   input wire [15:0] wdata_in,
   input wire ch2_slave_in,
   input wire [15:0] warn_limit_ch1_in,
   input wire [15:0] warn_limit_ch2_in,
   input wire [15:0] iout_ch1_in,
   input wire [15:0] iout_ch2_in,
   input wire clear_faults_in,
   output reg [15:0] rdata_out,
   output reg rvalid_out,
   output reg ack_out,
   output reg nack_out,
   output reg cml_out,
   output reg ivd_out,
   output reg invalid_command_flag_out,
   output reg alert_out,
   output reg [1:0] oc_fault_out
);
   // command decode
   wire hit;
   wire rd_hit;
   wire wr_hit;
   // page decode
   wire sel_ch1;
   wire sel_ch2;
   wire rd_ch2;
   // written word checks
   wire [10:0] wman;
   wire [10:0] warn_man_ch1;
   wire [10:0] warn_man_ch2;
   wire range_bad;
   wire below_warn_ch1;
   wire below_warn_ch2;
   wire below_warn;
   wire data_bad;
   wire slave_block;
   wire wr_ok;
   // per-channel store
   wire [10:0] man_ch [0:1];
   wire [15:0] iout_ch [0:1];
   wire [1:0] oc_now;
   wire [1:0] wr_ch;
   // next values of the registered outputs
   reg [15:0] nxt_rdata;
   wire nxt_rvalid;
   wire nxt_ack;
   wire nxt_nack;
   wire set_data_fault;
   wire set_cmd_fault;
   wire set_alert;
   wire [1:0] nxt_oc_fault;

   // measured currents indexed by channel for the generate loop
   assign iout_ch[0] = iout_ch1_in;
   assign iout_ch[1] = iout_ch2_in;

   // a transfer is ours only when the command code matches
   assign hit = (cmd_in == `OCFL_CMD_CODE);
   assign rd_hit = rd_in && hit;
   assign wr_hit = wr_in && hit;

   // page decode: ch2 slot only reachable for ch2 page or joint page
   assign sel_ch1 = (page_in == `OCFL_PAGE_CH1) || (page_in == `OCFL_PAGE_BOTH);
   assign sel_ch2 = (page_in == `OCFL_PAGE_CH2) || (page_in == `OCFL_PAGE_BOTH);
   // joint page and a slave ch2 both read back channel one's copy
   assign rd_ch2 = (page_in == `OCFL_PAGE_CH2) && !ch2_slave_in;

   // top five bits of the written word are read-only and never looked at
   assign wman = wdata_in[`OCFL_MAN_MSB:`OCFL_MAN_LSB];

   // signed range check keeps negative mantissas out too
   assign range_bad = ($signed(wman) < $signed(`OCFL_MAN_MIN)) ||
                      ($signed(wman) > $signed(`OCFL_MAN_MAX));

   // warning words carry the same fixed exponent, so mantissas compare directly;
   // a raw word compare would let the ignored top bits decide the result
   assign warn_man_ch1 = warn_limit_ch1_in[`OCFL_MAN_MSB:`OCFL_MAN_LSB];
   assign warn_man_ch2 = warn_limit_ch2_in[`OCFL_MAN_MSB:`OCFL_MAN_LSB];
   assign below_warn_ch1 = sel_ch1 && ($signed(wman) < $signed(warn_man_ch1));
   assign below_warn_ch2 = sel_ch2 && ($signed(wman) < $signed(warn_man_ch2));
   assign below_warn = below_warn_ch1 || below_warn_ch2;
   assign data_bad = below_warn || range_bad;

   // a slave ch2 may not be written, alone or through the joint page
   assign slave_block = sel_ch2 && ch2_slave_in;

   // a store needs a clean word on a writable page
   assign wr_ok = wr_hit && !slave_block && !data_bad;
   // a refused joint write stores in neither channel
   assign wr_ch[0] = wr_ok && sel_ch1;
   assign wr_ch[1] = wr_ok && sel_ch2;

   // one mantissa store and compare per channel
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ch
         ocfl_chan ocfl_chan_i (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .ce_in(ce_in),
            .wr_in(wr_ch[g]),
            .man_in(wman),
            .iout_in(iout_ch[g]),
            .man_out(man_ch[g]),
            .oc_out(oc_now[g])
         );
      end
   endgenerate

   // read word: exponent is a constant, never stored
   always @* begin
      nxt_rdata = rdata_out;
      if (rd_hit) begin
         if (rd_ch2) begin
            nxt_rdata = {`OCFL_EXP_FIXED, man_ch[1]};
         end else begin
            nxt_rdata = {`OCFL_EXP_FIXED, man_ch[0]};
         end
      end
   end

   // bus answers: ack also for a word refused for its value, nack for a slave page
   assign nxt_rvalid = rd_hit;
   assign nxt_ack = wr_hit && !slave_block;
   assign nxt_nack = wr_hit && slave_block;

   // fault events that set the sticky status bits
   assign set_data_fault = wr_hit && !slave_block && data_bad;
   assign set_cmd_fault = wr_hit && slave_block;
   assign set_alert = set_data_fault || set_cmd_fault;

   // a slave ch2 is watched through the master's compare, so its bit stays low
   assign nxt_oc_fault[0] = oc_now[0];
   assign nxt_oc_fault[1] = ch2_slave_in ? 1'b0 : oc_now[1];

   // read path and bus answers
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_out <= 16'h0000;
         rvalid_out <= 1'b0;
         ack_out <= 1'b0;
         nack_out <= 1'b0;
      end else if (ce_in) begin
         rdata_out <= nxt_rdata;
         rvalid_out <= nxt_rvalid;
         ack_out <= nxt_ack;
         nack_out <= nxt_nack;
      end
   end

   // data fault bits are sticky; a new event beats a same-cycle clear
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         cml_out <= 1'b0;
         ivd_out <= 1'b0;
      end else if (ce_in) begin
         if (set_data_fault) begin
            cml_out <= 1'b1;
            ivd_out <= 1'b1;
         end else if (clear_faults_in) begin
            cml_out <= 1'b0;
            ivd_out <= 1'b0;
         end
      end
   end

   // invalid command bit, same set-over-clear priority
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         invalid_command_flag_out <= 1'b0;
      end else if (ce_in) begin
         if (set_cmd_fault) begin
            invalid_command_flag_out <= 1'b1;
         end else if (clear_faults_in) begin
            invalid_command_flag_out <= 1'b0;
         end
      end
   end

   // alert stays up until the host clears the faults behind it
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         alert_out <= 1'b0;
      end else if (ce_in) begin
         if (set_alert) begin
            alert_out <= 1'b1;
         end else if (clear_faults_in) begin
            alert_out <= 1'b0;
         end
      end
   end

   // over-current bits are levels that follow the compares
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         oc_fault_out <= 2'h0;
      end else if (ce_in) begin
         oc_fault_out <= nxt_oc_fault;
      end
   end
endmodule // ocfl_top

// ---- verif/ocfl_monitor.sv ----
`timescale 1ns/1ps
module ocfl_monitor(input wire clk_in, rst_n_in, ce_in, wr_in, rd_in, ch2_slave_in,
   input wire [7:0] page_in, cmd_in, input wire [15:0] wdata_in, rdata_out,
   input wire rvalid_out, ack_out, nack_out, cml_out, ivd_out, alert_out,
   input wire invalid_command_flag_out, input wire [1:0] oc_fault_out);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // a negative mantissa reads as a large unsigned one, so one range test covers both ends
   wire w = ce_in && wr_in && cmd_in == 8'h46;
   wire s = ch2_slave_in && (page_in == 8'h01 || page_in == 8'h0b);
   property p_ex; rvalid_out |-> rdata_out[15:11] == 5'h1f; endproperty
   a_ex: assert property (p_ex) else $error("exponent");
   property p_mn; rvalid_out |-> rdata_out[10:0] inside {[6:100]}; endproperty
   a_mn: assert property (p_mn) else $error("mantissa");
   property p_rd; ce_in && rd_in && cmd_in == 8'h46 |=> rvalid_out; endproperty
   a_rd: assert property (p_rd) else $error("read");
   property p_ak; w && !s |=> ack_out && !nack_out; endproperty
   a_ak: assert property (p_ak) else $error("ack");
   property p_nk; w && s |=> nack_out && invalid_command_flag_out && alert_out; endproperty
   a_nk: assert property (p_nk) else $error("nack");
   property p_bd; w && !s && !(wdata_in[10:0] inside {[6:100]}) |=> ivd_out && cml_out; endproperty
   a_bd: assert property (p_bd) else $error("range");
   property p_al; alert_out |-> cml_out || invalid_command_flag_out; endproperty
   a_al: assert property (p_al) else $error("alert");
   property p_sl; ce_in && ch2_slave_in |=> !oc_fault_out[1]; endproperty
   a_sl: assert property (p_sl) else $error("slave");
   cover property (nack_out);
   cover property (ivd_out);
   cover property (oc_fault_out[0]);
endmodule // ocfl_monitor
bind ocfl_top ocfl_monitor ocfl_monitor_i(.*);

// ---- verif/ocfl_host.sv ----
`timescale 1ns/1ps
// host end: pages 00, 01, 0b; mantissa kept in 6..100 unless a refusal is wanted
module ocfl_host(input wire clk_in, output reg [7:0] cmd_out, page_out,
   output reg [15:0] wdata_out, output reg wr_out, rd_out);
   initial {cmd_out, page_out, wdata_out, wr_out, rd_out} = 34'h0;
   // request held for one edge, then released lines show junk, not the old word
   task xfer(input w, input [7:0] p, input [15:0] d);
      {cmd_out, page_out, wdata_out, wr_out, rd_out} <= {8'h46, p, d, w, !w};
      @(posedge clk_in) {cmd_out, wdata_out, wr_out, rd_out} <= {8'hb9, ~d, 2'b00};
   endtask
endmodule // ocfl_host

// ---- verif/ocfl_top_bench.sv ----
`timescale 1ns/1ps
module ocfl_top_bench;
   reg clk_in = 0, rst_n_in = 0, ce_in = 1, ch2_slave_in = 0, clear_faults_in = 0;
   reg [15:0] warn_limit_ch1_in = 16'hf806, warn_limit_ch2_in = 16'hf806;
   reg [15:0] iout_ch1_in = 16'h0006, iout_ch2_in = 16'h0063;
   wire [7:0] page_in, cmd_in;
   wire [15:0] wdata_in, rdata_out;
   wire [1:0] oc_fault_out;
   wire wr_in, rd_in, rvalid_out, ack_out, nack_out, cml_out, ivd_out, alert_out;
   wire invalid_command_flag_out;
   wire [5:0] flags = {ack_out, nack_out, cml_out, ivd_out, invalid_command_flag_out, alert_out};
   integer n_errors = 0, n_compared = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t value mismatch", $time); end end
   always #2 clk_in = ~clk_in;
   ocfl_host ocfl_host_i(.clk_in, .cmd_out(cmd_in), .page_out(page_in), .wdata_out(wdata_in),
      .wr_out(wr_in), .rd_out(rd_in));
   ocfl_top ocfl_top_i(.*);
   task stop_test;
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one transfer; every write is followed by a clear so each sees only its own flags
   task xf(input w, input [7:0] p, input [15:0] d, input [16:0] e);
      ocfl_host_i.xfer(w, p, d);
      #1 `CHK(w ? {11'h000, flags} : {rvalid_out, rdata_out}, e)
      @(posedge clk_in) clear_faults_in <= w;
   endtask
   // reset word, paging and read-only bits
   task t_page;
      xf(1'b0, 8'h01, 16'h0000, 17'h1f83c);
      xf(1'b1, 8'h01, 16'h0050, 17'h00020);
      xf(1'b0, 8'h00, 16'h0000, 17'h1f83c);
      xf(1'b1, 8'h0b, 16'h3864, 17'h00020);
      xf(1'b0, 8'h01, 16'h0000, 17'h1f864);
      xf(1'b1, 8'h00, 16'h0006, 17'h00020);
   endtask
   // refused words leave the old limit in place
   task t_bad;
      xf(1'b1, 8'h00, 16'h0005, 17'h0002d);
      xf(1'b1, 8'h00, 16'h0065, 17'h0002d);
      warn_limit_ch1_in <= 16'hf850;
      xf(1'b1, 8'h00, 16'h0040, 17'h0002d);
      xf(1'b0, 8'h00, 16'h0000, 17'h1f806);
   endtask
   // clock enable low: requests are ignored and every output holds
   task t_hold;
      ce_in <= 1'b0;
      xf(1'b1, 8'h00, 16'h0050, 17'h00000);
      xf(1'b0, 8'h00, 16'h0000, 17'h0f806);
      ce_in <= 1'b1;
      xf(1'b0, 8'h00, 16'h0000, 17'h1f806);
   endtask
   // compare below and at the limit, then channel two as slave
   task t_slave;
      #1 `CHK(oc_fault_out, 2'b01)
      @(posedge clk_in) iout_ch2_in <= 16'h0064;
      @(posedge clk_in) #1 `CHK(oc_fault_out, 2'b11)
      @(posedge clk_in) ch2_slave_in <= 1'b1;
      xf(1'b1, 8'h01, 16'h0050, 17'h00013);
      #1 `CHK(oc_fault_out, 2'b01)
      @(posedge clk_in);
      xf(1'b0, 8'h01, 16'h0000, 17'h1f806);
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_page;
      t_bad;
      t_hold;
      t_slave;
      stop_test;
   end
   initial begin
      #40000 n_errors++;
      stop_test;
   end
endmodule // ocfl_top_bench
